// ==== src/ssm_top.sv ====
// Supervisor and monitor mode selection with settle flags and wake hazard detection
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "ssm_map.svh"
module ssm_top (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  // Avalon-MM slave
  input  wire logic [`SSM_ADDR_W-1:0]    avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // Power mode
  input  wire logic                      lpm_entry,
  input  wire logic                      puc,
  input  wire logic                      wake_irq_pin,
  output logic                           in_deep,
  output logic                           wake,
  output logic                           locked,
  output logic                           irq,
  // Unit states
  output ssm_pkg::unit_state_t           core_sup_state,
  output ssm_pkg::unit_state_t           core_mon_state,
  output ssm_pkg::unit_state_t           supply_sup_state,
  output ssm_pkg::unit_state_t           supply_mon_state,
  output logic                           wake_slow
);

  // Register file and bus state
  ssm_pkg::ctl_t             core_ctl_ff;
  ssm_pkg::ctl_t             nxt_core_ctl;
  ssm_pkg::ctl_t             supply_ctl_ff;
  ssm_pkg::ctl_t             nxt_supply_ctl;
  logic [`SSM_IRQ_W-1:0]     irq_stat_ff;
  logic [`SSM_IRQ_W-1:0]     nxt_irq_stat;
  logic [`SSM_IRQ_W-1:0]     irq_mask_ff;
  logic [`SSM_IRQ_W-1:0]     nxt_irq_mask;
  logic [31:0]               readdata_ff;
  logic [31:0]               nxt_readdata;
  logic                      wait_ff;
  logic                      nxt_wait;
  logic                      irq_ff;
  logic                      nxt_irq;
  // Power state
  ssm_pkg::pm_state_t        pm_ff;
  ssm_pkg::pm_state_t        nxt_pm;
  logic [`SSM_WIN_CNT_W-1:0] win_ff;
  logic [`SSM_WIN_CNT_W-1:0] nxt_win;
  logic                      haz_lat_ff;
  logic                      nxt_haz_lat;
  logic                      wake_ff;
  logic                      nxt_wake;
  logic                      locked_ff;
  logic                      nxt_locked;
  logic                      in_deep_ff;
  logic                      nxt_in_deep;
  // Derived configuration state
  ssm_pkg::unit_state_t      core_sup_ff;
  ssm_pkg::unit_state_t      core_mon_ff;
  ssm_pkg::unit_state_t      supply_sup_ff;
  ssm_pkg::unit_state_t      supply_mon_ff;
  logic                      wake_slow_ff;
  logic                      hazard_ff;
  // Wake pin synchroniser
  logic                      irq_meta_ff;
  logic                      irq_s_ff;
  // Combinational helpers
  ssm_pkg::unit_state_t      core_sup_c;
  ssm_pkg::unit_state_t      core_mon_c;
  ssm_pkg::unit_state_t      supply_sup_c;
  ssm_pkg::unit_state_t      supply_mon_c;
  logic                      deep;
  logic                      core_fast;
  logic                      supply_hit;
  logic                      hazard_c;
  logic                      wr_go;
  logic                      core_wr;
  logic                      supply_wr;
  logic                      core_busy;
  logic                      supply_busy;
  logic                      core_done;
  logic                      supply_done;
  logic                      ev_haz;
  logic                      ev_early;
  logic                      ev_lost;
  logic [15:0]               lane_mask;

  // Control register word from its struct
  function automatic logic [31:0] ctl_word(input ssm_pkg::ctl_t c);
    logic [31:0] w;
    w                   = 32'h0;
    w[`SSM_BIT_SUP_EN]   = c.sup_enable;
    w[`SSM_BIT_SUP_KEEP] = c.sup_lpm_keep;
    w[`SSM_BIT_SUP_FP]   = c.sup_full_perf;
    w[`SSM_BIT_MON_EN]   = c.mon_enable;
    w[`SSM_BIT_MON_FP]   = c.mon_full_perf;
    w[`SSM_BIT_AUTO]     = c.auto_ctrl;
    return w;
  endfunction

  // Byte-lane merge of a write into a control register
  function automatic ssm_pkg::ctl_t ctl_merge(input ssm_pkg::ctl_t c, input logic [15:0] d,
                                              input logic [15:0] m);
    logic [31:0]   cw;
    logic [15:0]   w;
    ssm_pkg::ctl_t r;
    cw              = ctl_word(c);
    w               = (cw[15:0] & ~m) | (d & m);
    r.sup_enable    = w[`SSM_BIT_SUP_EN];
    r.sup_lpm_keep  = w[`SSM_BIT_SUP_KEEP];
    r.sup_full_perf = w[`SSM_BIT_SUP_FP];
    r.mon_enable    = w[`SSM_BIT_MON_EN];
    r.mon_full_perf = w[`SSM_BIT_MON_FP];
    r.auto_ctrl     = w[`SSM_BIT_AUTO];
    return r;
  endfunction

  // Locked still counts as a low-power mode for the mapping
  assign deep = (pm_ff != ssm_pkg::PM_ACTIVE);

  // State mapping of the four units
  ssm_unit_state u_core_sup (
    .enable(core_ctl_ff.sup_enable), .lpm_keep(core_ctl_ff.sup_lpm_keep),
    .full_perf(core_ctl_ff.sup_full_perf), .auto_ctrl(core_ctl_ff.auto_ctrl),
    .deep(deep), .state(core_sup_c));
  ssm_unit_state u_core_mon (
    .enable(core_ctl_ff.mon_enable), .lpm_keep(1'b1),
    .full_perf(core_ctl_ff.mon_full_perf), .auto_ctrl(core_ctl_ff.auto_ctrl),
    .deep(deep), .state(core_mon_c));
  ssm_unit_state u_supply_sup (
    .enable(supply_ctl_ff.sup_enable), .lpm_keep(supply_ctl_ff.sup_lpm_keep),
    .full_perf(supply_ctl_ff.sup_full_perf), .auto_ctrl(supply_ctl_ff.auto_ctrl),
    .deep(deep), .state(supply_sup_c));
  ssm_unit_state u_supply_mon (
    .enable(supply_ctl_ff.mon_enable), .lpm_keep(1'b1),
    .full_perf(supply_ctl_ff.mon_full_perf), .auto_ctrl(supply_ctl_ff.auto_ctrl),
    .deep(deep), .state(supply_mon_c));

  // Hazard: core side first, then the supply side cases
  always_comb begin
    core_fast  = !core_ctl_ff.sup_enable || core_ctl_ff.sup_full_perf ||
                 !core_ctl_ff.mon_enable || core_ctl_ff.mon_full_perf;
    supply_hit = (supply_ctl_ff.sup_enable && !supply_ctl_ff.sup_full_perf &&
                  (!supply_ctl_ff.sup_lpm_keep || supply_ctl_ff.auto_ctrl)) ||
                 (supply_ctl_ff.mon_enable && !supply_ctl_ff.mon_full_perf &&
                  supply_ctl_ff.auto_ctrl);
    hazard_c   = core_fast && supply_hit;
  end

  // Settle timers restart on each accepted control write
  assign wr_go     = avs_write && !wait_ff;
  assign core_wr   = wr_go && (avs_address == `SSM_OFS_CORE_CTL);
  assign supply_wr = wr_go && (avs_address == `SSM_OFS_SUPPLY_CTL);
  assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  ssm_settle_timer u_core_settle (
    .clk(clk), .rst_n(rst_n), .ce(ce), .start(core_wr),
    .long_sel(!nxt_core_ctl.sup_full_perf), .busy(core_busy), .done(core_done));
  ssm_settle_timer u_supply_settle (
    .clk(clk), .rst_n(rst_n), .ce(ce), .start(supply_wr),
    .long_sel(!nxt_supply_ctl.sup_full_perf), .busy(supply_busy), .done(supply_done));

  // Power mode machine; a hit inside the window locks until reset or clear
  always_comb begin
    nxt_pm      = pm_ff;
    nxt_win     = win_ff;
    nxt_haz_lat = haz_lat_ff;
    nxt_wake    = 1'b0;
    ev_haz      = 1'b0;
    ev_early    = 1'b0;
    ev_lost     = 1'b0;
    case (pm_ff)
      ssm_pkg::PM_ACTIVE: begin
        if (lpm_entry) begin
          nxt_pm      = ssm_pkg::PM_DEEP;
          nxt_win     = `SSM_WIN_CNT_W'(`SSM_HAZ_WIN_CYC);
          nxt_haz_lat = hazard_ff;
          ev_haz      = hazard_ff;
          ev_early    = core_busy || supply_busy;
        end
      end
      ssm_pkg::PM_DEEP: begin
        if (win_ff != '0) begin
          nxt_win = win_ff - `SSM_WIN_CNT_W'(1);
        end
        if (irq_s_ff) begin
          if (haz_lat_ff && (win_ff != '0)) begin
            nxt_pm  = ssm_pkg::PM_LOCKED;
            ev_lost = 1'b1;
          end else begin
            nxt_pm   = ssm_pkg::PM_ACTIVE;
            nxt_wake = 1'b1;
          end
        end
      end
      ssm_pkg::PM_LOCKED: begin
        nxt_pm = ssm_pkg::PM_LOCKED;
      end
      default: begin
        nxt_pm = ssm_pkg::PM_ACTIVE;
      end
    endcase
    if (puc) begin
      nxt_pm   = ssm_pkg::PM_ACTIVE;
      nxt_wake = 1'b0;
    end
    nxt_locked = (nxt_pm == ssm_pkg::PM_LOCKED);
    nxt_in_deep = (nxt_pm != ssm_pkg::PM_ACTIVE);
  end

  // Bus slave: one wait cycle, then a single answer cycle
  always_comb begin
    nxt_core_ctl   = core_ctl_ff;
    nxt_supply_ctl = supply_ctl_ff;
    nxt_irq_mask   = irq_mask_ff;
    nxt_readdata   = readdata_ff;
    nxt_wait       = !((avs_read || avs_write) && wait_ff);
    if (core_wr) begin
      nxt_core_ctl = ctl_merge(core_ctl_ff, avs_writedata[15:0], lane_mask);
    end else if (supply_wr) begin
      nxt_supply_ctl = ctl_merge(supply_ctl_ff, avs_writedata[15:0], lane_mask);
    end else if (wr_go && (avs_address == `SSM_OFS_IRQ_MASK) && avs_byteenable[0]) begin
      nxt_irq_mask = avs_writedata[`SSM_IRQ_W-1:0];
    end
    // Set wins over a same-cycle clear so no event is lost
    nxt_irq_stat = irq_stat_ff;
    if (wr_go && (avs_address == `SSM_OFS_IRQ_STAT) && avs_byteenable[0]) begin
      nxt_irq_stat = irq_stat_ff & ~avs_writedata[`SSM_IRQ_W-1:0];
    end
    nxt_irq_stat[`SSM_IRQ_CORE_DONE]   = nxt_irq_stat[`SSM_IRQ_CORE_DONE] | core_done;
    nxt_irq_stat[`SSM_IRQ_SUPPLY_DONE] = nxt_irq_stat[`SSM_IRQ_SUPPLY_DONE] | supply_done;
    nxt_irq_stat[`SSM_IRQ_HAZ_ENTRY]   = nxt_irq_stat[`SSM_IRQ_HAZ_ENTRY] | ev_haz;
    nxt_irq_stat[`SSM_IRQ_EARLY_ENTRY] = nxt_irq_stat[`SSM_IRQ_EARLY_ENTRY] | ev_early;
    nxt_irq_stat[`SSM_IRQ_LOST_WAKE]   = nxt_irq_stat[`SSM_IRQ_LOST_WAKE] | ev_lost;
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
    // Read data is latched as waitrequest falls; unmapped reads give zero
    if (avs_read && wait_ff) begin
      nxt_readdata = 32'h0;
      if (avs_address == `SSM_OFS_CORE_CTL) begin
        nxt_readdata = ctl_word(core_ctl_ff);
      end else if (avs_address == `SSM_OFS_SUPPLY_CTL) begin
        nxt_readdata = ctl_word(supply_ctl_ff);
      end else if (avs_address == `SSM_OFS_STATUS) begin
        nxt_readdata[`SSM_ST_CORE_SUP +: 2]   = core_sup_ff;
        nxt_readdata[`SSM_ST_CORE_MON +: 2]   = core_mon_ff;
        nxt_readdata[`SSM_ST_SUPPLY_SUP +: 2] = supply_sup_ff;
        nxt_readdata[`SSM_ST_SUPPLY_MON +: 2] = supply_mon_ff;
        nxt_readdata[`SSM_ST_WAKE_SLOW]       = wake_slow_ff;
        nxt_readdata[`SSM_ST_HAZARD]          = hazard_ff;
        nxt_readdata[`SSM_ST_CORE_SETTLE]     = core_busy;
        nxt_readdata[`SSM_ST_SUPPLY_SETTLE]   = supply_busy;
        nxt_readdata[`SSM_ST_DEEP]            = deep;
        nxt_readdata[`SSM_ST_LOCKED]          = locked_ff;
      end else if (avs_address == `SSM_OFS_IRQ_STAT) begin
        nxt_readdata[`SSM_IRQ_W-1:0] = irq_stat_ff;
      end else if (avs_address == `SSM_OFS_IRQ_MASK) begin
        nxt_readdata[`SSM_IRQ_W-1:0] = irq_mask_ff;
      end
    end
  end

  // Registers; the wake pin passes two flops before any logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_ctl_ff   <= `SSM_CTL_RST;
      supply_ctl_ff <= `SSM_CTL_RST;
      irq_stat_ff   <= `SSM_IRQ_RST;
      irq_mask_ff   <= `SSM_IRQ_RST;
      readdata_ff   <= 32'h0;
      wait_ff       <= 1'b1;
      irq_ff        <= 1'b0;
      pm_ff         <= ssm_pkg::PM_ACTIVE;
      win_ff        <= '0;
      haz_lat_ff    <= 1'b0;
      wake_ff       <= 1'b0;
      locked_ff     <= 1'b0;
      in_deep_ff    <= 1'b0;
      core_sup_ff   <= ssm_pkg::US_OFF;
      core_mon_ff   <= ssm_pkg::US_OFF;
      supply_sup_ff <= ssm_pkg::US_OFF;
      supply_mon_ff <= ssm_pkg::US_OFF;
      wake_slow_ff  <= 1'b0;
      hazard_ff     <= 1'b0;
      irq_meta_ff   <= 1'b0;
      irq_s_ff      <= 1'b0;
    end else if (ce) begin
      core_ctl_ff   <= nxt_core_ctl;
      supply_ctl_ff <= nxt_supply_ctl;
      irq_stat_ff   <= nxt_irq_stat;
      irq_mask_ff   <= nxt_irq_mask;
      readdata_ff   <= nxt_readdata;
      wait_ff       <= nxt_wait;
      irq_ff        <= nxt_irq;
      pm_ff         <= nxt_pm;
      win_ff        <= nxt_win;
      haz_lat_ff    <= nxt_haz_lat;
      wake_ff       <= nxt_wake;
      locked_ff     <= nxt_locked;
      in_deep_ff    <= nxt_in_deep;
      core_sup_ff   <= core_sup_c;
      core_mon_ff   <= core_mon_c;
      supply_sup_ff <= supply_sup_c;
      supply_mon_ff <= supply_mon_c;
      wake_slow_ff  <= (core_ctl_ff.sup_enable && !core_ctl_ff.sup_full_perf) ||
                       (core_ctl_ff.mon_enable && !core_ctl_ff.mon_full_perf);
      hazard_ff     <= hazard_c;
      irq_meta_ff   <= wake_irq_pin;
      irq_s_ff      <= irq_meta_ff;
    end
  end

  // Outputs, each straight from its flop
  assign avs_readdata     = readdata_ff;
  assign avs_waitrequest  = wait_ff;
  assign in_deep          = in_deep_ff;
  assign wake             = wake_ff;
  assign locked           = locked_ff;
  assign irq              = irq_ff;
  assign core_sup_state   = core_sup_ff;
  assign core_mon_state   = core_mon_ff;
  assign supply_sup_state = supply_sup_ff;
  assign supply_mon_state = supply_mon_ff;
  assign wake_slow        = wake_slow_ff;

  // Run length of the core settle flag; a counter stands in for a long delay range
  logic [`SSM_SETTLE_CNT_W-1:0] core_run_ff;
  logic [`SSM_SETTLE_CNT_W-1:0] nxt_core_run;

  always_comb begin
    nxt_core_run = '0;
    if (core_busy && !core_wr) begin
      nxt_core_run = core_run_ff + `SSM_SETTLE_CNT_W'(1);
    end
  end

  // Run counter register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_run_ff <= '0;
    end else if (ce) begin
      core_run_ff <= nxt_core_run;
    end
  end

  // Checks; frozen cycles are excluded since state holds then
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  sequence s_early_hit;
    pm_ff == ssm_pkg::PM_DEEP && haz_lat_ff && win_ff != '0 && irq_s_ff && !puc;
  endsequence

  sequence s_no_clear;
    (!puc && ce)[*3];
  endsequence

  chk_core_sup_off: assert property (
    !core_ctl_ff.sup_enable |=> core_sup_ff == ssm_pkg::US_OFF)
    else $error("core supervisor not off while disabled");
  chk_core_sup_active: assert property (
    core_ctl_ff.sup_enable && !deep && core_ctl_ff.sup_full_perf
    |=> core_sup_ff == ssm_pkg::US_FULL)
    else $error("core supervisor not full performance in active mode");
  chk_core_sup_auto: assert property (
    core_ctl_ff.sup_enable && deep && core_ctl_ff.auto_ctrl &&
    !(core_ctl_ff.sup_lpm_keep && core_ctl_ff.sup_full_perf)
    |=> core_sup_ff == ssm_pkg::US_OFF)
    else $error("core supervisor not off in automatic deep mode");
  chk_core_mon_auto: assert property (
    core_ctl_ff.mon_enable && deep && core_ctl_ff.auto_ctrl && core_ctl_ff.mon_full_perf
    |=> core_mon_ff == ssm_pkg::US_NORMAL)
    else $error("core monitor not normal in automatic deep mode");
  chk_wake_slow_sel: assert property (
    (core_ctl_ff.sup_enable && !core_ctl_ff.sup_full_perf) |=> wake_slow_ff)
    else $error("slow wake not selected");
  chk_supply_keep_map: assert property (
    supply_ctl_ff.sup_enable && deep && !supply_ctl_ff.auto_ctrl &&
    supply_ctl_ff.sup_lpm_keep && !supply_ctl_ff.sup_full_perf
    |=> supply_sup_ff == ssm_pkg::US_NORMAL)
    else $error("supply supervisor not kept normal");
  chk_hazard_core_gate: assert property (
    hazard_ff |-> $past(core_ctl_ff.sup_enable) == 1'b0 || $past(core_ctl_ff.sup_full_perf) ||
    !$past(core_ctl_ff.mon_enable) || $past(core_ctl_ff.mon_full_perf))
    else $error("hazard flagged without core fast wake");
  chk_hazard_entry_flag: assert property (
    pm_ff == ssm_pkg::PM_ACTIVE && lpm_entry && hazard_ff && !puc
    |=> irq_stat_ff[`SSM_IRQ_HAZ_ENTRY] && deep)
    else $error("hazardous entry not flagged");
  chk_lost_wake_lock: assert property (
    s_early_hit ##1 s_no_clear |-> locked_ff && !wake_ff)
    else $error("early wake in hazard window did not lock");
  chk_settle_after_write: assert property (
    core_wr |=> core_busy)
    else $error("settle flag not raised after write");
  chk_settle_run_bound: assert property (
    core_run_ff <= `SSM_SETTLE_CNT_W'(`SSM_SETTLE_NORM_CYC))
    else $error("settle flag held longer than the slow delay");
  chk_settle_run_length: assert property (
    $fell(core_busy) |-> (core_run_ff == `SSM_SETTLE_CNT_W'(`SSM_SETTLE_FP_CYC)) ||
    (core_run_ff == `SSM_SETTLE_CNT_W'(`SSM_SETTLE_NORM_CYC)))
    else $error("settle flag released after a wrong number of cycles");

endmodule

// ==== src/ssm_map.svh ====
// Register map, field positions, reset values and timing counts of the supervisor mode block
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH

// Byte offsets on the register bus
`define SSM_ADDR_W           5
`define SSM_OFS_CORE_CTL     5'h00
`define SSM_OFS_SUPPLY_CTL   5'h04
`define SSM_OFS_STATUS       5'h08
`define SSM_OFS_IRQ_STAT     5'h0c
`define SSM_OFS_IRQ_MASK     5'h10

// Control register fields, same layout on both sides
`define SSM_BIT_SUP_EN       0
`define SSM_BIT_SUP_KEEP     1
`define SSM_BIT_SUP_FP       2
`define SSM_BIT_MON_EN       4
`define SSM_BIT_MON_FP       5
`define SSM_BIT_AUTO         8
`define SSM_CTL_RST          6'h00

// Status register fields
`define SSM_ST_CORE_SUP      0
`define SSM_ST_CORE_MON      2
`define SSM_ST_SUPPLY_SUP    4
`define SSM_ST_SUPPLY_MON    6
`define SSM_ST_WAKE_SLOW     8
`define SSM_ST_HAZARD        9
`define SSM_ST_CORE_SETTLE   10
`define SSM_ST_SUPPLY_SETTLE 11
`define SSM_ST_DEEP          12
`define SSM_ST_LOCKED        13

// Interrupt status and mask fields
`define SSM_IRQ_W            5
`define SSM_IRQ_RST          5'h00
`define SSM_IRQ_CORE_DONE    0
`define SSM_IRQ_SUPPLY_DONE  1
`define SSM_IRQ_HAZ_ENTRY    2
`define SSM_IRQ_EARLY_ENTRY  3
`define SSM_IRQ_LOST_WAKE    4

// Timing
`define SSM_CLK_MHZ          10
`define SSM_SETTLE_FP_NS     2000
`define SSM_SETTLE_NORM_NS   150000
`define SSM_HAZ_WIN_NS       1000
`define SSM_SETTLE_FP_CYC    ((`SSM_SETTLE_FP_NS * `SSM_CLK_MHZ + 999) / 1000)
`define SSM_SETTLE_NORM_CYC  ((`SSM_SETTLE_NORM_NS * `SSM_CLK_MHZ + 999) / 1000)
`define SSM_HAZ_WIN_CYC      ((`SSM_HAZ_WIN_NS * `SSM_CLK_MHZ) / 1000)
`define SSM_SETTLE_CNT_W     11
`define SSM_WIN_CNT_W        4

`endif

// ==== src/ssm_pkg.sv ====
// Types shared by the supervisor mode block
package ssm_pkg;

  typedef enum logic [1:0] {
    US_OFF    = 2'b00,
    US_NORMAL = 2'b01,
    US_FULL   = 2'b10
  } unit_state_t;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_DEEP   = 2'b01,
    PM_LOCKED = 2'b10
  } pm_state_t;

  typedef struct packed {
    logic auto_ctrl;
    logic mon_full_perf;
    logic mon_enable;
    logic sup_full_perf;
    logic sup_lpm_keep;
    logic sup_enable;
  } ctl_t;

endpackage

// ==== src/ssm_unit_state.sv ====
// Maps one supervisor or monitor setting and power mode to its operating state
`timescale 1ns/1ps
module ssm_unit_state (
  // Settings
  input  wire logic               enable,
  input  wire logic               lpm_keep,
  input  wire logic               full_perf,
  input  wire logic               auto_ctrl,
  // Power mode
  input  wire logic               deep,
  // Result
  output ssm_pkg::unit_state_t    state
);

  // A monitor has no keep bit; it is wired high so manual deep keeps its state
  always_comb begin
    state = ssm_pkg::US_OFF;
    if (!enable) begin
      state = ssm_pkg::US_OFF;
    end else if (!deep) begin
      state = full_perf ? ssm_pkg::US_FULL : ssm_pkg::US_NORMAL;
    end else if (!auto_ctrl) begin
      if (lpm_keep) begin
        state = full_perf ? ssm_pkg::US_FULL : ssm_pkg::US_NORMAL;
      end
    end else if (lpm_keep && full_perf) begin
      state = ssm_pkg::US_NORMAL;
    end
  end

endmodule

// ==== src/ssm_settle_timer.sv ====
// Settling delay counter behind one side's settle flag
`timescale 1ns/1ps
`include "ssm_map.svh"
module ssm_settle_timer (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Control
  input  wire logic start,
  input  wire logic long_sel,
  // Flags
  output logic      busy,
  output logic      done
);

  logic [`SSM_SETTLE_CNT_W-1:0] cnt_ff;
  logic [`SSM_SETTLE_CNT_W-1:0] nxt_cnt;
  logic                         busy_ff;
  logic                         nxt_busy;
  logic                         done_ff;
  logic                         nxt_done;

  // A new write restarts the delay, so the flag covers the latest setting
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_cnt  = long_sel ? `SSM_SETTLE_CNT_W'(`SSM_SETTLE_NORM_CYC)
                          : `SSM_SETTLE_CNT_W'(`SSM_SETTLE_FP_CYC);
      nxt_busy = 1'b1;
    end else if (busy_ff) begin
      nxt_cnt = cnt_ff - `SSM_SETTLE_CNT_W'(1);
      if (cnt_ff == `SSM_SETTLE_CNT_W'(1)) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;

endmodule

// ==== tb/ssm_top_tb_top.sv ====
// Self-checking bench for the supervisor mode selection block
`timescale 1ns/1ps
`include "ssm_map.svh"
module ssm_top_tb_top;
  logic                 clk, rst_n, ce, avs_read, avs_write, lpm_entry, puc, wake_irq_pin;
  logic [4:0]           avs_address;
  logic [31:0]          avs_writedata, avs_readdata, q;
  logic [3:0]           avs_byteenable;
  logic                 avs_waitrequest, in_deep, wake, locked, irq, wake_slow;
  ssm_pkg::unit_state_t cs, cm, ss, sm;
  int                   num_errors, total_checks;

  ssm_top DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lpm_entry(lpm_entry), .puc(puc),
    .wake_irq_pin(wake_irq_pin), .in_deep(in_deep), .wake(wake), .locked(locked),
    .irq(irq), .core_sup_state(cs), .core_mon_state(cm), .supply_sup_state(ss),
    .supply_mon_state(sm), .wake_slow(wake_slow));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus access; request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      finish_test();
    end
    @(posedge clk);
  endtask

  // Pulse deep entry (k=0) or power-up clear (k=1), then let states follow
  task automatic pulse(input int k);
    if (k == 0) lpm_entry <= 1'b1;
    else puc <= 1'b1;
    @(posedge clk);
    lpm_entry <= 1'b0;
    puc       <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Expected unit state; monitors pass keep as 1
  function automatic ssm_pkg::unit_state_t es(logic en, logic kp, logic fp, logic au, logic dp);
    if (!en) return ssm_pkg::US_OFF;
    if (!dp || (!au && kp)) return fp ? ssm_pkg::US_FULL : ssm_pkg::US_NORMAL;
    return (au && kp && fp) ? ssm_pkg::US_NORMAL : ssm_pkg::US_OFF;
  endfunction

  function automatic logic [31:0] mk(input logic [5:0] i);
    return {23'h0, i[5], 2'h0, i[4], i[3], 1'b0, i[2], i[1], i[0]};
  endfunction

  task automatic chkst(input logic [31:0] c, input logic [31:0] s, input logic d);
    chk({30'h0, cs}, {30'h0, es(c[0], c[1], c[2], c[8], d)});
    chk({30'h0, cm}, {30'h0, es(c[4], 1'b1, c[5], c[8], d)});
    chk({30'h0, ss}, {30'h0, es(s[0], s[1], s[2], s[8], d)});
    chk({30'h0, sm}, {30'h0, es(s[4], 1'b1, s[5], s[8], d)});
  endtask

  // Every core setting combination with the supply side as its complement, active and deep, with the hazard check
  task automatic t_map();
    logic [31:0] c, s;
    logic        hz;
    for (int i = 0; i < 64; i++) begin
      c = mk(i[5:0]);
      s = mk(~i[5:0]);
      acc(1'b1, `SSM_OFS_CORE_CTL, c);
      acc(1'b1, `SSM_OFS_SUPPLY_CTL, s);
      acc(1'b0, `SSM_OFS_STATUS, 32'h0);
      hz = (!c[0] | c[2] | !c[4] | c[5]) &
           ((s[0] & !s[2] & (!s[1] | s[8])) | (s[4] & !s[5] & s[8]));
      chk({31'h0, q[9]}, {31'h0, hz});
      if ((c[0] & !c[2]) == (c[4] & !c[5])) chk({31'h0, wake_slow}, {31'h0, c[0] & !c[2]});
      chkst(c, s, 1'b0);
      pulse(0);
      chkst(c, s, 1'b1);
      pulse(1);
    end
  endtask

  // Hazardous entry with an early wake locks; otherwise a wake returns
  task automatic t_wake(input logic [31:0] sup, input logic haz);
    int n;
    acc(1'b1, `SSM_OFS_CORE_CTL, 32'h005);
    acc(1'b1, `SSM_OFS_SUPPLY_CTL, sup);
    n = 0;
    do begin
      acc(1'b0, `SSM_OFS_STATUS, 32'h0);
      n++;
    end while (q[11:10] !== 2'h0 && n < 1000);
    chk({30'h0, q[11:10]}, 32'h0);
    if (q[11:10] !== 2'h0) finish_test();
    acc(1'b0, `SSM_OFS_IRQ_STAT, 32'h0);
    chk({30'h0, q[1:0]}, 32'h3);
    acc(1'b1, `SSM_OFS_IRQ_STAT, 32'h1f);
    acc(1'b1, `SSM_OFS_IRQ_MASK, 32'h1f);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    lpm_entry    <= 1'b1;
    wake_irq_pin <= 1'b1;
    @(posedge clk);
    lpm_entry <= 1'b0;
    n = 0;
    while (locked !== 1'b1 && wake !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, locked}, {31'h0, haz});
    chk({31'h0, wake}, {31'h0, !haz});
    if (locked !== 1'b1 && wake !== 1'b1) finish_test();
    acc(1'b0, `SSM_OFS_IRQ_STAT, 32'h0);
    chk(q, haz ? 32'h14 : 32'h0);
    chk({31'h0, irq}, {31'h0, haz});
    acc(1'b1, `SSM_OFS_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, `SSM_OFS_IRQ_STAT, 32'h1f);
    acc(1'b0, `SSM_OFS_IRQ_STAT, 32'h0);
    chk(q, 32'h0);
    wake_irq_pin <= 1'b0;
    pulse(1);
    chk({30'h0, locked, in_deep}, 32'h0);
  endtask

  // Reset, then the scenarios
  initial begin
    {rst_n, avs_read, avs_write, lpm_entry, puc, wake_irq_pin} <= 6'h0;
    {ce, avs_byteenable, avs_address, avs_writedata} <= {1'b1, 4'hf, 5'h00, 32'h0};
    num_errors   = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    acc(1'b0, `SSM_OFS_CORE_CTL, 32'h0);
    chk(q, 32'h0);
    acc(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0);
    t_map();
    acc(1'b0, `SSM_OFS_IRQ_STAT, 32'h0);
    chk({30'h0, q[3:2]}, 32'h3);
    t_wake(32'h001, 1'b1);
    t_wake(32'h003, 1'b0);
    finish_test();
  end
endmodule
